/* hdl/synth_ctrl_pkg.sv */
// Constants for the synthesizer control register set
package synth_ctrl_pkg;
  // ****************************************************************
  // Word and select field
  // ****************************************************************
  localparam int         WORD_W     = 32;
  localparam int         SEL_W      = 3;
  localparam logic [2:0] SEL_FREQ   = 3'h0;
  localparam logic [2:0] SEL_FRACLO = 3'h1;
  localparam logic [2:0] SEL_REFDIV = 3'h2;
  localparam logic [2:0] SEL_FUNC   = 3'h3;
  localparam logic [2:0] SEL_TEST   = 3'h4;
  localparam logic [31:0] LATCH_RST = 32'h0000_0000;

  // ****************************************************************
  // Field positions and widths
  // ****************************************************************
  localparam int MON_LSB    = 27;
  localparam int MON_W      = 4;
  localparam int INT_LSB    = 15;
  localparam int INT_W      = 12;
  localparam int FHI_LSB    = 3;
  localparam int FHI_W      = 12;
  localparam int FLO_LSB    = 15;
  localparam int FLO_W      = 13;
  localparam int CSR_BIT    = 28;
  localparam int PUMP_LSB   = 24;
  localparam int PUMP_W     = 4;
  localparam int PRESC_BIT  = 22;
  localparam int HALVE_BIT  = 21;
  localparam int DBL_BIT    = 20;
  localparam int RCNT_LSB   = 15;
  localparam int RCNT_W     = 5;
  localparam int MODRST_BIT = 14;
  localparam int LDP_BIT    = 7;
  localparam int POL_BIT    = 6;
  localparam int PD_BIT     = 5;
  localparam int TRI_BIT    = 4;
  localparam int CRST_BIT   = 3;
  localparam int TEST_LSB   = 3;
  localparam int TEST_W     = 29;

  // ****************************************************************
  // Lock detect counts and monitor selections
  // ****************************************************************
  localparam int         LOCK_W      = 6;
  localparam logic [5:0] LOCK_CNT_LO = 6'h18;
  localparam logic [5:0] LOCK_CNT_HI = 6'h28;
  localparam logic [3:0] MON_LOW     = 4'h0;
  localparam logic [3:0] MON_LOCK    = 4'h1;
  localparam logic [3:0] MON_PFDREF  = 4'h2;
  localparam logic [3:0] MON_WINDOW  = 4'h3;
endpackage

/* hdl/ref_path.sv */
// Reference doubler, R counter and halver giving the PHASE_FREQ_DETECTOR reference tick
`timescale 1ns/1ps
module ref_path (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       ref_pin,
  input  wire logic       doubler,
  input  wire logic       halve,
  input  wire logic [4:0] r_ratio,
  input  wire logic       hold,
  output logic            pfd_tick,
  output logic            pfd_level
);
  typedef struct packed {
    logic [2:0] sync;
    logic       ref_f;
    logic [4:0] cnt;
    logic       half;
    logic       tick;
    logic       level;
  } ref_state_t;

  ref_state_t s_q;
  ref_state_t s_d;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic active;
    logic rtick;
    active = 1'b0;
    rtick  = 1'b0;
    s_d      = s_q;
    s_d.tick = 1'b0;
    s_d.sync = {s_q.sync[1:0], ref_pin};
    // Filtered reference edge: falling only, or both with doubler
    if (s_q.sync[1] == s_q.sync[2] && s_q.sync[2] != s_q.ref_f) begin
      s_d.ref_f = s_q.sync[2];
      active    = doubler || !s_q.sync[2];
    end
    // Ratio 1..32, code 0 counts as 32 since the compare wraps
    if (active) begin
      if (s_q.cnt == r_ratio - 5'h01) begin
        s_d.cnt = 5'h00;
        rtick   = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 5'h01;
      end
    end
    // Optional divide-by-two toggle stage
    if (rtick) begin
      s_d.half = !s_q.half;
      if (!halve || s_q.half) begin
        s_d.tick  = 1'b1;
        s_d.level = !s_q.level;
      end
    end
    // Counters held in their load state
    if (hold) begin
      s_d.cnt  = 5'h00;
      s_d.half = 1'b0;
      s_d.tick = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pfd_tick  = s_q.tick;
  assign pfd_level = s_q.level;
endmodule // ref_path

/* hdl/synth_ctrl_regs.sv */
// Serial programming port, control latches and lock detect
//
// Notes on behaviour
// - Shift 32 bits MSB first, select low three
// - Load strobe rise copies word to selected latch
// - Double-buffered fields apply on next frequency write
// - Select 000 loads the frequency word
// - Select 001 loads the fraction low word
// - Select 010 loads the reference divider word
// - Select 011 loads the function word
// - Select 100 loads test word, upper zero
// - Bits 30..27 select the monitor output
// - Twelve-bit integer divide value from frequency word
// - Fraction is low thirteen plus high shifted
// - Reference word bits 27..24 set pump current
// - Cycle slip reduction only with positive polarity
// - Halving bit adds divide-by-two after R counter
// - Doubler off falling edge, on both edges
// - R counter divides reference by 1 to 32
// - Modulator reset on frequency write unless bit14
// - Lock after 24 or 40 good cycles
// - Function bit 6 sets detector polarity
// - Power-down keeps all latched contents
// - Power-down holds counters, tristates pump, clears lock
// - Function bit 4 tristates the charge pump
// - Function bit 3 holds counters in reset
`timescale 1ns/1ps
module synth_ctrl_regs (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        SER_CLK,
  input  wire logic        SER_DATA,
  input  wire logic        LOAD_STROBE,
  input  wire logic        REFERENCE_INPUT,
  input  wire logic        PHASE_IN_WINDOW,
  output logic             MONITOR_OUTPUT_PIN,
  output logic [3:0]       MON_SEL,
  output logic [11:0]      INT_VALUE,
  output logic [24:0]      FRAC_VALUE,
  output logic [3:0]       PUMP_CURRENT,
  output logic             PRESCALER_89,
  output logic             CYCLE_SLIP_REDUCE,
  output logic             REF_DOUBLER,
  output logic             REF_HALVE,
  output logic [4:0]       R_RATIO,
  output logic             PFD_REF_TICK,
  output logic             MOD_RESET,
  output logic             LOCK_DETECT,
  output logic             PD_POLARITY,
  output logic             POWER_DOWN,
  output logic             PUMP_TRISTATE,
  output logic             COUNTER_RESET,
  output logic [28:0]      TEST_BITS
);
  typedef struct packed {
    logic [2:0]  ser_sync;
    logic [2:0]  dat_sync;
    logic [2:0]  le_sync;
    logic [2:0]  win_sync;
    logic        ser_f;
    logic        le_f;
    logic        win_f;
    logic [31:0] shift;
    logic [31:0] freq;
    logic [31:0] frac_word;
    logic [31:0] ref_word;
    logic [31:0] func;
    logic [31:0] test;
    logic [12:0] frac_act;
    logic [4:0]  rcnt_act;
    logic        dbl_act;
    logic [3:0]  pump_act;
    logic [5:0]  lock_cnt;
    logic        lock;
    logic        mod_rst;
    logic        mon_out;
    logic        tri_o;
    logic        crst_o;
    logic        csr_o;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  logic        ser_rise;
  logic        load_rise;
  logic [2:0]  sel;
  logic [5:0]  lock_target;
  logic        pfd_tick;
  logic        pfd_level;

  // ****************************************************************
  // Reference path
  // ****************************************************************
  ref_path u_ref (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .ref_pin   (REFERENCE_INPUT),
    .doubler   (s_q.dbl_act),
    .halve     (s_q.ref_word[synth_ctrl_pkg::HALVE_BIT]),
    .r_ratio   (s_q.rcnt_act),
    .hold      (s_q.crst_o),
    .pfd_tick  (pfd_tick),
    .pfd_level (pfd_level)
  );

  // Filtered edges of the serial pins, select field, lock target
  assign ser_rise  = s_q.ser_sync[1] == s_q.ser_sync[2] && s_q.ser_sync[2] && !s_q.ser_f;
  assign load_rise = s_q.le_sync[1] == s_q.le_sync[2] && s_q.le_sync[2] && !s_q.le_f;
  assign sel       = s_q.shift[2:0];
  assign lock_target = s_q.func[synth_ctrl_pkg::LDP_BIT] ? synth_ctrl_pkg::LOCK_CNT_HI
                                                         : synth_ctrl_pkg::LOCK_CNT_LO;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [5:0] nxt;
    nxt = 6'h00;
    s_d         = s_q;
    s_d.mod_rst = 1'b0;
    s_d.ser_sync = {s_q.ser_sync[1:0], SER_CLK};
    s_d.dat_sync = {s_q.dat_sync[1:0], SER_DATA};
    s_d.le_sync  = {s_q.le_sync[1:0], LOAD_STROBE};
    s_d.win_sync = {s_q.win_sync[1:0], PHASE_IN_WINDOW};
    // Filtered levels follow once stages two and three agree
    if (s_q.ser_sync[1] == s_q.ser_sync[2]) begin
      s_d.ser_f = s_q.ser_sync[2];
    end
    if (s_q.le_sync[1] == s_q.le_sync[2]) begin
      s_d.le_f = s_q.le_sync[2];
    end
    if (s_q.win_sync[1] == s_q.win_sync[2]) begin
      s_d.win_f = s_q.win_sync[2];
    end
    // Shift in MSB first on serial clock rise
    if (ser_rise) begin
      s_d.shift = {s_q.shift[30:0], s_q.dat_sync[2]};
    end
    // Latch transfer, accepted in power-down too
    if (load_rise) begin
      case (sel)
        synth_ctrl_pkg::SEL_FREQ: begin
          s_d.freq     = s_q.shift;
          s_d.frac_act = s_q.frac_word[synth_ctrl_pkg::FLO_LSB +: synth_ctrl_pkg::FLO_W];
          s_d.rcnt_act = s_q.ref_word[synth_ctrl_pkg::RCNT_LSB +: synth_ctrl_pkg::RCNT_W];
          s_d.dbl_act  = s_q.ref_word[synth_ctrl_pkg::DBL_BIT];
          s_d.pump_act = s_q.ref_word[synth_ctrl_pkg::PUMP_LSB +: synth_ctrl_pkg::PUMP_W];
          s_d.mod_rst  = !s_q.func[synth_ctrl_pkg::MODRST_BIT];
        end
        synth_ctrl_pkg::SEL_FRACLO: begin
          s_d.frac_word = s_q.shift;
        end
        synth_ctrl_pkg::SEL_REFDIV: begin
          s_d.ref_word = s_q.shift;
        end
        synth_ctrl_pkg::SEL_FUNC: begin
          s_d.func = s_q.shift;
        end
        synth_ctrl_pkg::SEL_TEST: begin
          s_d.test = s_q.shift;
        end
        default: begin
          s_d.test = s_q.test;
        end
      endcase
    end
    // Lock detect counts good PHASE_FREQ_DETECTOR cycles, restarts on a bad one
    if (s_q.func[synth_ctrl_pkg::PD_BIT]) begin
      s_d.lock_cnt = 6'h00;
      s_d.lock     = 1'b0;
    end else if (pfd_tick) begin
      if (s_q.win_f) begin
        nxt = (s_q.lock_cnt >= lock_target) ? s_q.lock_cnt : s_q.lock_cnt + 6'h01;
        s_d.lock_cnt = nxt;
        s_d.lock     = nxt >= lock_target;
      end else begin
        s_d.lock_cnt = 6'h00;
        s_d.lock     = 1'b0;
      end
    end
    // Pump three-state, counter hold and cycle slip gating
    s_d.tri_o  = s_q.func[synth_ctrl_pkg::TRI_BIT] | s_q.func[synth_ctrl_pkg::PD_BIT];
    s_d.crst_o = s_q.func[synth_ctrl_pkg::CRST_BIT] | s_q.func[synth_ctrl_pkg::PD_BIT];
    s_d.csr_o  = s_q.ref_word[synth_ctrl_pkg::CSR_BIT] & s_q.func[synth_ctrl_pkg::POL_BIT];
    // Monitor multiplexer
    case (s_q.freq[synth_ctrl_pkg::MON_LSB +: synth_ctrl_pkg::MON_W])
      synth_ctrl_pkg::MON_LOW:    s_d.mon_out = 1'b0;
      synth_ctrl_pkg::MON_LOCK:   s_d.mon_out = s_q.lock;
      synth_ctrl_pkg::MON_PFDREF: s_d.mon_out = pfd_level;
      synth_ctrl_pkg::MON_WINDOW: s_d.mon_out = s_q.win_f;
      default:                    s_d.mon_out = 1'b0;
    endcase
  end

  // State register
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign MONITOR_OUTPUT_PIN = s_q.mon_out;
  assign MON_SEL            = s_q.freq[synth_ctrl_pkg::MON_LSB +: synth_ctrl_pkg::MON_W];
  assign INT_VALUE          = s_q.freq[synth_ctrl_pkg::INT_LSB +: synth_ctrl_pkg::INT_W];
  assign FRAC_VALUE         = {s_q.freq[synth_ctrl_pkg::FHI_LSB +: synth_ctrl_pkg::FHI_W],
                               s_q.frac_act};
  assign PUMP_CURRENT       = s_q.pump_act;
  assign PRESCALER_89       = s_q.ref_word[synth_ctrl_pkg::PRESC_BIT];
  assign CYCLE_SLIP_REDUCE  = s_q.csr_o;
  assign REF_DOUBLER        = s_q.dbl_act;
  assign REF_HALVE          = s_q.ref_word[synth_ctrl_pkg::HALVE_BIT];
  assign R_RATIO            = s_q.rcnt_act;
  assign PFD_REF_TICK       = pfd_tick;
  assign MOD_RESET          = s_q.mod_rst;
  assign LOCK_DETECT        = s_q.lock;
  assign PD_POLARITY        = s_q.func[synth_ctrl_pkg::POL_BIT];
  assign POWER_DOWN         = s_q.func[synth_ctrl_pkg::PD_BIT];
  assign PUMP_TRISTATE      = s_q.tri_o;
  assign COUNTER_RESET      = s_q.crst_o;
  assign TEST_BITS          = s_q.test[synth_ctrl_pkg::TEST_LSB +: synth_ctrl_pkg::TEST_W];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  shift_in_a: assert property (ser_rise |=>
    s_q.shift == {$past(s_q.shift[30:0]), $past(s_q.dat_sync[2])})
    else $error("shift register did not take serial bit");
  freq_load_a: assert property (load_rise && sel == synth_ctrl_pkg::SEL_FREQ |=>
    s_q.freq == $past(s_q.shift))
    else $error("frequency word not loaded");
  frac_load_a: assert property (load_rise && sel == synth_ctrl_pkg::SEL_FRACLO |=>
    s_q.frac_word == $past(s_q.shift))
    else $error("fraction low word not loaded");
  ref_load_a: assert property (load_rise && sel == synth_ctrl_pkg::SEL_REFDIV |=>
    s_q.ref_word == $past(s_q.shift))
    else $error("reference word not loaded");
  func_load_a: assert property (load_rise && sel == synth_ctrl_pkg::SEL_FUNC |=>
    s_q.func == $past(s_q.shift))
    else $error("function word not loaded");
  test_load_a: assert property (load_rise && sel == synth_ctrl_pkg::SEL_TEST |=>
    s_q.test == $past(s_q.shift))
    else $error("test word not loaded");
  dbuf_hold_a: assert property (load_rise && sel != synth_ctrl_pkg::SEL_FREQ |=>
    $stable(FRAC_VALUE[12:0]) && $stable(PUMP_CURRENT) && $stable(R_RATIO))
    else $error("double-buffered field changed early");
  ignore_sel_a: assert property (load_rise && sel > synth_ctrl_pkg::SEL_TEST |=>
    $stable(s_q.freq) && $stable(s_q.func) && $stable(s_q.ref_word) && $stable(s_q.test) &&
    $stable(s_q.frac_word))
    else $error("unused select changed a latch");
  mod_reset_a: assert property (load_rise && sel == synth_ctrl_pkg::SEL_FREQ |=>
    MOD_RESET == !$past(s_q.func[synth_ctrl_pkg::MODRST_BIT]))
    else $error("modulator reset pulse wrong");
  lock_rise_a: assert property ($rose(LOCK_DETECT) |->
    s_q.lock_cnt == lock_target && $past(pfd_tick))
    else $error("lock asserted before count");
  pd_force_a: assert property (s_q.func[synth_ctrl_pkg::PD_BIT] |=>
    PUMP_TRISTATE && COUNTER_RESET && !LOCK_DETECT)
    else $error("power-down effects missing");
  csr_pol_a: assert property (CYCLE_SLIP_REDUCE |->
    $past(s_q.func[synth_ctrl_pkg::POL_BIT]))
    else $error("cycle slip enabled with negative polarity");

  // Derived outputs, double-buffered transfer and held state
  cnt_hold_a: assert property (COUNTER_RESET |=> !PFD_REF_TICK)
    else $error("reference tick while counters held");
  crst_bit_a: assert property (s_q.func[synth_ctrl_pkg::CRST_BIT] |=> COUNTER_RESET)
    else $error("counter reset bit not applied");
  tri_bit_a: assert property (s_q.func[synth_ctrl_pkg::TRI_BIT] |=> PUMP_TRISTATE)
    else $error("three-state bit not applied");
  mon_lock_a: assert property (MON_SEL == synth_ctrl_pkg::MON_LOCK |=>
    MONITOR_OUTPUT_PIN == $past(LOCK_DETECT))
    else $error("monitor does not follow lock detect");
  lock_drop_a: assert property (pfd_tick && !s_q.win_f |=>
    !LOCK_DETECT && s_q.lock_cnt == 6'h00)
    else $error("lock count kept after a bad cycle");
  frac_apply_a: assert property (load_rise && sel == synth_ctrl_pkg::SEL_FREQ |=>
    FRAC_VALUE == {$past(s_q.shift[synth_ctrl_pkg::FHI_LSB +: synth_ctrl_pkg::FHI_W]),
                   $past(s_q.frac_word[synth_ctrl_pkg::FLO_LSB +: synth_ctrl_pkg::FLO_W])})
    else $error("fraction value not applied");
  ratio_apply_a: assert property (load_rise && sel == synth_ctrl_pkg::SEL_FREQ |=>
    R_RATIO == $past(s_q.ref_word[synth_ctrl_pkg::RCNT_LSB +: synth_ctrl_pkg::RCNT_W]) &&
    PUMP_CURRENT == $past(s_q.ref_word[synth_ctrl_pkg::PUMP_LSB +: synth_ctrl_pkg::PUMP_W]) &&
    REF_DOUBLER == $past(s_q.ref_word[synth_ctrl_pkg::DBL_BIT]))
    else $error("double-buffered fields not applied");
  pd_keep_a: assert property (POWER_DOWN && !load_rise |=>
    $stable(s_q.freq) && $stable(s_q.frac_word) && $stable(s_q.ref_word) &&
    $stable(s_q.func) && $stable(s_q.test))
    else $error("latch changed in power-down");
  mod_quiet_a: assert property (MOD_RESET |->
    $past(load_rise) && $past(sel) == synth_ctrl_pkg::SEL_FREQ)
    else $error("modulator reset without frequency write");
  shift_hold_a: assert property (!ser_rise |=> $stable(s_q.shift))
    else $error("shift register moved without serial clock");
endmodule // synth_ctrl_regs

/* sim/serial_host_model.sv */
// Host side of the three-wire programming link
`timescale 1ns/1ps
module serial_host_model (
  input  wire logic clk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      load_strobe
);
  // ****************************************************************
  // Idle levels
  // ****************************************************************
  initial begin
    ser_clk     = 1'b0;
    ser_data    = 1'b0;
    load_strobe = 1'b0;
  end

  // Count falling edges of the system clock
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Shift one word MSB first, then raise the strobe; clock and strobe levels last 4 clocks, each data bit 6
  // The caller keeps zeros in reserved bits and the documented write order
  task automatic send_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      ser_data = w[i];
      wait_cyc(4);
      ser_clk  = 1'b1;
      wait_cyc(2);
      ser_data = ~w[i];             // Hold time over, stale value is not kept
      wait_cyc(2);
      ser_clk  = 1'b0;
    end
    wait_cyc(4);
    load_strobe = 1'b1;
    wait_cyc(4);
    load_strobe = 1'b0;
  endtask
endmodule // serial_host_model

/* sim/test_synth_ctrl_regs.sv */
// Self-checking bench for the synthesizer control register set
`timescale 1ns/1ps
module test_synth_ctrl_regs;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk, reset_n, ref_in, window;
  logic        ser_clk, ser_data, load_strobe;
  logic        mon_pin, presc, cycle_slip_reduce, dbl, halve, tick, mod_rst, lock;
  logic        pol, pd, tri_st, cnt_rst;
  logic [3:0]  mon_sel, pump;
  logic [11:0] int_val;
  logic [24:0] frac;
  logic [4:0]  r_ratio;
  logic [28:0] test_bits;
  int          bad_count, total_checks, cyc, mod_cnt;

  serial_host_model serial_host_model_i (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data),
    .load_strobe(load_strobe));

  synth_ctrl_regs synth_ctrl_regs_i (.CLK(clk), .RESET_N(reset_n), .SER_CLK(ser_clk),
    .SER_DATA(ser_data), .LOAD_STROBE(load_strobe), .REFERENCE_INPUT(ref_in),
    .PHASE_IN_WINDOW(window), .MONITOR_OUTPUT_PIN(mon_pin), .MON_SEL(mon_sel),
    .INT_VALUE(int_val), .FRAC_VALUE(frac), .PUMP_CURRENT(pump), .PRESCALER_89(presc),
    .CYCLE_SLIP_REDUCE(cycle_slip_reduce), .REF_DOUBLER(dbl), .REF_HALVE(halve), .R_RATIO(r_ratio),
    .PFD_REF_TICK(tick), .MOD_RESET(mod_rst), .LOCK_DETECT(lock), .PD_POLARITY(pol),
    .POWER_DOWN(pd), .PUMP_TRISTATE(tri_st), .COUNTER_RESET(cnt_rst), .TEST_BITS(test_bits));

  // ****************************************************************
  // Clock, reference, timeout and pulse counter
  // ****************************************************************
  initial clk = 1'b0;
  always #50 clk = ~clk;
  // Reference toggles on falling clock edges, 4 clocks per level
  initial ref_in = 1'b0;
  always #400 ref_in = ~ref_in;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mod_rst === 1'b1) mod_cnt <= mod_cnt + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      final_report();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Send a word and let the latches and derived outputs settle
  task automatic put(input logic [31:0] w);
    serial_host_model_i.send_word(w);
    repeat (6) @(negedge clk);
  endtask

  // Wait for a reference tick, sampled at falling edges
  task automatic wait_tick();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tick !== 1'b1 && n < 400);
  endtask

  function automatic logic [31:0] fn_word(input logic modrst, input logic pdown);
    return {17'h00000, modrst, 6'h00, 1'h0, 1'h1, pdown, 1'h0, 1'h0, 3'h3};
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Power-up order, double buffering and field positions
  task automatic init_sequence();
    int m0;
    put({29'h00000000, 3'h4});
    check("test bits", test_bits, 32'h0);
    put(fn_word(1'b0, 1'b0));
    check("polarity", pol, 32'h1);
    put({3'h0, 1'h1, 4'hA, 1'h0, 1'h1, 1'h0, 1'h0, 5'h03, 12'h000, 3'h2});
    check("prescaler", presc, 32'h1);
    check("pump held", pump, 32'h0);
    check("ratio held", r_ratio, 32'h0);
    put({4'h0, 13'h1ABC, 12'h000, 3'h1});
    check("frac held", frac, 32'h0);
    m0 = mod_cnt;
    put({1'h0, 4'h1, 12'h244, 12'h051, 3'h0});
    check("mod reset", mod_cnt - m0, 32'h1);
    check("mon sel", mon_sel, 32'h1);
    check("int", int_val, 32'h244);
    check("frac", frac, {7'h00, 12'h051, 13'h1ABC});
    check("pump", pump, 32'hA);
    check("ratio", r_ratio, 32'h3);
    check("doubler", dbl, 32'h0);
    check("halve", halve, 32'h0);
    check("slip", cycle_slip_reduce, 32'h1);
  endtask

  // Unused select codes leave every latch alone
  task automatic ignored_selects();
    for (int s = 5; s <= 7; s++) begin
      put({1'h0, 4'h3, 12'hFFF, 12'hFFF, s[2:0]});
      check("int kept", int_val, 32'h244);
      check("test kept", test_bits, 32'h0);
      check("pump kept", pump, 32'hA);
    end
  endtask

  // Tick spacing, lock after 24 good cycles, loss on a bad cycle
  task automatic lock_detect();
    int t0, n;
    wait_tick();
    t0 = cyc;
    wait_tick();
    check("tick spacing", cyc - t0, 32'd24);
    window = 1'b1;
    n = 0;
    do begin
      wait_tick();
      n++;
      repeat (3) @(negedge clk);
    end while (lock !== 1'b1 && n < 60);
    check("ticks to lock", n, 32'd24);
    check("monitor", mon_pin, 32'h1);
    window = 1'b0;
    wait_tick();
    repeat (3) @(negedge clk);
    check("lock lost", lock, 32'h0);
  endtask

  // Power-down keeps contents and still accepts words
  task automatic power_down();
    int m0;
    window = 1'b1;
    repeat (26) wait_tick();
    check("locked again", lock, 32'h1);
    put(fn_word(1'b1, 1'b1));
    check("power down", pd, 32'h1);
    check("tristate", tri_st, 32'h1);
    check("counter reset", cnt_rst, 32'h1);
    check("lock cleared", lock, 32'h0);
    check("int retained", int_val, 32'h244);
    m0 = mod_cnt;
    put({1'h0, 4'h1, 12'h300, 12'h051, 3'h0});
    check("int loaded", int_val, 32'h300);
    check("no mod reset", mod_cnt - m0, 32'h0);
  endtask

  // Three-state and counter hold alone; negative polarity blocks slip reduction
  task automatic func_bits();
    int n;
    put({24'h000000, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 3'h3});
    check("pd off", pd, 32'h0);
    check("tristate bit", tri_st, 32'h1);
    check("counter bit", cnt_rst, 32'h1);
    check("negative pol", pol, 32'h0);
    check("slip gated", cycle_slip_reduce, 32'h0);
    n = 0;
    repeat (100) begin
      @(negedge clk);
      if (tick === 1'b1) n++;
    end
    check("ticks held", n, 32'h0);
  endtask

  // Doubler and halver timing, 40-cycle lock precision, window on the monitor
  task automatic ref_modes();
    int t0, n;
    put(fn_word(1'b0, 1'b0) | 32'h0000_0080);
    put({3'h0, 1'h0, 4'h5, 1'h0, 1'h0, 1'h1, 1'h1, 5'h02, 12'h000, 3'h2});
    check("halve now", halve, 32'h1);
    check("doubler held", dbl, 32'h0);
    put({1'h0, 4'h3, 12'h300, 12'h051, 3'h0});
    check("doubler", dbl, 32'h1);
    check("ratio two", r_ratio, 32'h2);
    check("pump five", pump, 32'h5);
    wait_tick();
    t0 = cyc;
    wait_tick();
    check("halved spacing", cyc - t0, 32'd16);
    window = 1'b0;
    repeat (2) wait_tick();
    window = 1'b1;
    n = 0;
    do begin
      wait_tick();
      n++;
      repeat (3) @(negedge clk);
    end while (lock !== 1'b1 && n < 60);
    check("ticks to lock 40", n, 32'd40);
    check("monitor window", mon_pin, 32'h1);
    window = 1'b0;
    repeat (6) @(negedge clk);
    check("monitor low", mon_pin, 32'h0);
  endtask

  // Reset in mid-run clears every latch
  task automatic reset_again();
    @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    check("int after reset", int_val, 32'h0);
    check("ratio after reset", r_ratio, 32'h0);
    check("halve after reset", halve, 32'h0);
    check("lock after reset", lock, 32'h0);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    reset_n      = 1'b0;
    window       = 1'b0;
    bad_count    = 0;
    total_checks = 0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    check("int at reset", int_val, 32'h0);
    check("lock at reset", lock, 32'h0);
    check("pd at reset", pd, 32'h0);
    repeat (4) @(negedge clk);
    init_sequence();
    ignored_selects();
    lock_detect();
    power_down();
    func_bits();
    ref_modes();
    reset_again();
    final_report();
  end
endmodule // test_synth_ctrl_regs
